/* File: logic/pci_phy_ctrl.v */
// phy-specific control register bank with interrupt pin, collision gate and loopback fifo
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pci_regs.vh"

module pci_phy_ctrl #(
    parameter NEVT = 8
) (
    input wire i_mclk, // system clock, 50 MHz
    input wire i_rst_b, // async reset, active low
    input wire i_wb_cyc, // wishbone cycle
    input wire i_wb_stb, // wishbone strobe
    input wire i_wb_we, // wishbone write
    input wire [9:0] i_wb_adr, // wishbone byte address
    input wire [3:0] i_wb_sel, // wishbone byte selects
    input wire [31:0] i_wb_dat, // wishbone write data
    output reg [31:0] o_wb_dat, // wishbone read data
    output reg o_wb_ack, // wishbone acknowledge
    input wire [NEVT-1:0] i_event, // event pulses from phy core
    input wire i_full_duplex, // link in full duplex
    input wire i_col_raw, // collision from receive logic
    output reg o_col, // collision toward mac
    input wire i_far_loop, // far-end loopback mode active
    input wire i_lb_wr, // receive nibble strobe
    input wire [3:0] i_lb_rxd, // receive nibble
    input wire i_lb_rd, // transmit side nibble request
    output wire [3:0] o_lb_txd, // looped-back nibble
    output wire o_lb_valid, // looped nibble valid
    input wire i_irq_powerdown_shared_pin, // shared pin level in
    output reg o_irq_powerdown_shared_pin, // shared pin level out
    output reg o_irq_powerdown_shared_pin_oe, // shared pin driven
    output reg o_powerdown, // power-down requested by pin
    output wire o_irq // block interrupt, active high
);
    reg [15:0] phy_specific_control;
    reg [`PCI_IRQ_W-1:0] irq_stat_ff;
    reg [`PCI_IRQ_W-1:0] irq_mask_ff;
    reg [`PCI_IRQ_W-1:0] nxt_irq_stat;
    reg [31:0] nxt_rdata;
    reg int_active;
    wire req;
    wire wr_ctrl;
    wire wr_evt;
    wire rd_evt;
    wire rd_stat;
    wire wr_mask;
    wire [NEVT-1:0] evt_status;
    wire [NEVT-1:0] evt_enable;
    wire evt_pending;
    wire lb_err;
    wire [15:0] ctrl_wdata;
    reg [15:0] nxt_ctrl;
    reg int_active_d_ff;
    reg sel_ctrl;
    reg sel_evt;
    reg sel_stat;
    reg sel_mask;
    reg sel_link;

    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;

    // one select per register; unmapped addresses select nothing
    always @* begin
        sel_ctrl = 1'b0;
        sel_evt = 1'b0;
        sel_stat = 1'b0;
        sel_mask = 1'b0;
        sel_link = 1'b0;
        if (i_wb_adr == `PCI_ADDR_CTRL) begin
            sel_ctrl = 1'b1;
        end else if (i_wb_adr == `PCI_ADDR_EVT) begin
            sel_evt = 1'b1;
        end else if (i_wb_adr == `PCI_ADDR_IRQ_STAT) begin
            sel_stat = 1'b1;
        end else if (i_wb_adr == `PCI_ADDR_IRQ_MASK) begin
            sel_mask = 1'b1;
        end else if (i_wb_adr == `PCI_ADDR_LINK) begin
            sel_link = 1'b1;
        end
    end

    assign wr_ctrl = req && i_wb_we && sel_ctrl;
    assign wr_evt = req && i_wb_we && sel_evt && i_wb_sel[0];
    assign rd_evt = req && !i_wb_we && sel_evt;
    assign rd_stat = req && !i_wb_we && sel_stat;
    assign wr_mask = req && i_wb_we && sel_mask && i_wb_sel[0];
    assign ctrl_wdata = i_wb_dat[15:0] & `PCI_CTRL_WMASK;

    // byte lanes of the control word
    always @* begin
        nxt_ctrl = phy_specific_control;
        if (i_wb_sel[0]) begin
            nxt_ctrl[7:0] = ctrl_wdata[7:0];
        end
        if (i_wb_sel[1]) begin
            nxt_ctrl[15:8] = ctrl_wdata[15:8];
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phy_specific_control <= `PCI_CTRL_RESET;
        end else if (wr_ctrl) begin
            phy_specific_control <= nxt_ctrl;
        end
    end

    pci_evt_latch #(
        .N(NEVT)
    ) u_evt (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_event(i_event),
        .i_clr(rd_evt),
        .i_en_wdata(i_wb_dat[NEVT-1:0]),
        .i_en_we(wr_evt),
        .o_status(evt_status),
        .o_enable(evt_enable),
        .o_pending(evt_pending)
    );

    pci_lb_fifo #(
        .SLOTS(`PCI_FIFO_SLOTS)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_enable(i_far_loop),
        .i_depth_code(phy_specific_control[`PCI_F_DEPTH_HI:`PCI_F_DEPTH_LO]),
        .i_wr(i_lb_wr),
        .i_wdata(i_lb_rxd),
        .i_rd(i_lb_rd),
        .o_rdata(o_lb_txd),
        .o_valid(o_lb_valid),
        .o_err(lb_err)
    );

    always @* begin
        int_active = (phy_specific_control[`PCI_F_GIE] && evt_pending)
            || phy_specific_control[`PCI_F_TEST];
    end

    // collision toward the mac, one cycle after the raw indication
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_col <= 1'b0;
        end else begin
            o_col <= i_col_raw
                && (!i_full_duplex || phy_specific_control[`PCI_F_COLFD]);
        end
    end

    // polarity 1 means idle high, low during interrupt
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq_powerdown_shared_pin <= 1'b0;
        end else begin
            o_irq_powerdown_shared_pin <= phy_specific_control[`PCI_F_POL]
                ^ int_active;
        end
    end

    // the pin is driven only while it serves as interrupt output
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq_powerdown_shared_pin_oe <= 1'b0;
        end else begin
            o_irq_powerdown_shared_pin_oe <=
                phy_specific_control[`PCI_F_IOE];
        end
    end

    // power-down only while the pin is an input held low
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_powerdown <= 1'b0;
        end else begin
            o_powerdown <= !phy_specific_control[`PCI_F_IOE]
                && !i_irq_powerdown_shared_pin;
        end
    end

    // previous interrupt state, for the rising-edge status bit
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_active_d_ff <= 1'b0;
        end else begin
            int_active_d_ff <= int_active;
        end
    end

    // sticky block status: read clears, new event wins
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (rd_stat) begin
            nxt_irq_stat = {`PCI_IRQ_W{1'b0}};
        end
        if (int_active && !int_active_d_ff && !phy_specific_control[`PCI_F_TEST]) begin
            nxt_irq_stat[`PCI_IRQ_EVT] = 1'b1;
        end
        if (lb_err) begin
            nxt_irq_stat[`PCI_IRQ_FIFO] = 1'b1;
        end
        if (phy_specific_control[`PCI_F_TEST]) begin
            nxt_irq_stat[`PCI_IRQ_TEST] = 1'b1;
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat_ff <= {`PCI_IRQ_W{1'b0}};
            irq_mask_ff <= {`PCI_IRQ_W{1'b0}};
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask) begin
                irq_mask_ff <= i_wb_dat[`PCI_IRQ_W-1:0];
            end
        end
    end

    assign o_irq = |(irq_stat_ff & irq_mask_ff);

    // read mux; unmapped addresses read zero and still acknowledge
    always @* begin
        nxt_rdata = 32'h00000000;
        if (sel_ctrl) begin
            nxt_rdata[15:0] = phy_specific_control;
        end else if (sel_evt) begin
            nxt_rdata[15:0] = {evt_status, evt_enable};
        end else if (sel_stat) begin
            nxt_rdata[`PCI_IRQ_W-1:0] = irq_stat_ff;
        end else if (sel_mask) begin
            nxt_rdata[`PCI_IRQ_W-1:0] = irq_mask_ff;
        end else if (sel_link) begin
            nxt_rdata[3:0] = {i_far_loop, i_full_duplex, int_active, o_powerdown};
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= req;
            if (req && !i_wb_we) begin
                o_wb_dat <= nxt_rdata;
            end
        end
    end
endmodule
`default_nettype wire

/* File: common/pci_regs.vh */
// register offsets, field positions and reset values for the phy control block
`ifndef PCI_REGS_VH
`define PCI_REGS_VH

// register byte addresses (printed offsets are indices, byte address is index*4)
`define PCI_IDX_CTRL 8'h11
`define PCI_IDX_EVT 8'h12
`define PCI_IDX_IRQ_STAT 8'h20
`define PCI_IDX_IRQ_MASK 8'h21
`define PCI_IDX_LINK 8'h22
`define PCI_ADDR_CTRL 10'h044
`define PCI_ADDR_EVT 10'h048
`define PCI_ADDR_IRQ_STAT 10'h080
`define PCI_ADDR_IRQ_MASK 10'h084
`define PCI_ADDR_LINK 10'h088

// control register fields
`define PCI_CTRL_RESET 16'h0108
`define PCI_CTRL_WMASK 16'h031F
`define PCI_F_DEPTH_HI 9
`define PCI_F_DEPTH_LO 8
`define PCI_F_COLFD 4
`define PCI_F_POL 3
`define PCI_F_TEST 2
`define PCI_F_GIE 1
`define PCI_F_IOE 0

// loopback depth codes in nibbles
`define PCI_DEPTH_00 4'h4
`define PCI_DEPTH_01 4'h5
`define PCI_DEPTH_10 4'h6
`define PCI_DEPTH_11 4'h8
`define PCI_FIFO_SLOTS 8

// block interrupt status bits
`define PCI_IRQ_W 3
`define PCI_IRQ_EVT 0
`define PCI_IRQ_FIFO 1
`define PCI_IRQ_TEST 2

`endif

/* File: logic/pci_lb_fifo.v */
// far-end loopback elastic nibble fifo with selectable fill depth
`timescale 1ns/10ps
`default_nettype none
`include "pci_regs.vh"

module pci_lb_fifo #(
    parameter SLOTS = `PCI_FIFO_SLOTS
) (
    input wire i_mclk, // system clock
    input wire i_rst_b, // async reset, active low
    input wire i_enable, // loopback active
    input wire [1:0] i_depth_code, // depth select
    input wire i_wr, // nibble from receive side
    input wire [3:0] i_wdata, // receive nibble
    input wire i_rd, // transmit side takes a nibble
    output reg [3:0] o_rdata, // transmit nibble
    output reg o_valid, // o_rdata holds fresh data
    output reg o_err // overflow or underflow flag, high one cycle after a refused write or a read while primed and empty
);
    reg [3:0] mem [0:SLOTS-1];
    reg [2:0] wp_ff;
    reg [2:0] rp_ff;
    reg [3:0] cnt_ff;
    reg primed_ff;
    reg [3:0] depth;
    wire do_wr;
    wire do_rd;

    always @* begin
        case (i_depth_code)
            2'b00: depth = `PCI_DEPTH_00;
            2'b01: depth = `PCI_DEPTH_01;
            2'b10: depth = `PCI_DEPTH_10;
            default: depth = `PCI_DEPTH_11;
        endcase
    end

    // reading waits until the chosen depth has been filled, absorbing clock skew
    assign do_wr = i_enable && i_wr && (cnt_ff < depth);
    assign do_rd = i_enable && i_rd && primed_ff && (cnt_ff != 4'h0);

    always @(posedge i_mclk) begin
        if (do_wr) begin
            mem[wp_ff] <= i_wdata;
        end
    end

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_ff <= 3'h0;
            rp_ff <= 3'h0;
            cnt_ff <= 4'h0;
            primed_ff <= 1'b0;
            o_rdata <= 4'h0;
            o_valid <= 1'b0;
            o_err <= 1'b0;
        end else if (!i_enable) begin
            wp_ff <= 3'h0;
            rp_ff <= 3'h0;
            cnt_ff <= 4'h0;
            primed_ff <= 1'b0;
            o_valid <= 1'b0;
            o_err <= 1'b0;
        end else begin
            if (do_wr) begin
                wp_ff <= wp_ff + 3'h1;
            end
            if (do_rd) begin
                rp_ff <= rp_ff + 3'h1;
                o_rdata <= mem[rp_ff];
            end
            cnt_ff <= cnt_ff + {3'h0, do_wr} - {3'h0, do_rd};
            if (cnt_ff + {3'h0, do_wr} >= depth) begin
                primed_ff <= 1'b1;
            end else if (cnt_ff == 4'h0 && !do_wr) begin
                primed_ff <= 1'b0;
            end
            o_valid <= do_rd;
            o_err <= (i_wr && !(cnt_ff < depth)) || (i_rd && primed_ff && cnt_ff == 4'h0);
        end
    end
endmodule
`default_nettype wire

/* File: logic/pci_evt_latch.v */
// per-event latched-high status bits with their enables
`timescale 1ns/10ps
`default_nettype none
`include "pci_regs.vh"

module pci_evt_latch #(
    parameter N = 8
) (
    input wire i_mclk, // system clock
    input wire i_rst_b, // async reset, active low
    input wire [N-1:0] i_event, // one-cycle event pulses
    input wire i_clr, // status read clears latched bits
    input wire [N-1:0] i_en_wdata, // new enables
    input wire i_en_we, // enable write strobe
    output reg [N-1:0] o_status, // latched event bits
    output reg [N-1:0] o_enable, // per-event enables
    output wire o_pending // some enabled event is latched
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_evt
            always @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_status[g] <= 1'b0;
                    o_enable[g] <= 1'b0;
                end else begin
                    // a new event wins over the clearing read
                    if (i_event[g]) begin
                        o_status[g] <= 1'b1;
                    end else if (i_clr) begin
                        o_status[g] <= 1'b0;
                    end
                    if (i_en_we) begin
                        o_enable[g] <= i_en_wdata[g];
                    end
                end
            end
        end
    endgenerate

    assign o_pending = |(o_status & o_enable);
endmodule
`default_nettype wire

/* File: sim/pci_phy_ctrl_props.sv */
// port assertions for the phy control block
`timescale 1ns/10ps
`default_nettype none
`include "pci_regs.vh"
module pci_phy_ctrl_chk (
    input wire logic i_mclk, // clock
    input wire logic i_rst_b, // reset
    input wire logic i_wb_cyc, // cycle
    input wire logic i_wb_stb, // strobe
    input wire logic i_wb_we, // write
    input wire logic [9:0] i_wb_adr, // address
    input wire logic [3:0] i_wb_sel, // lanes
    input wire logic [31:0] i_wb_dat, // wdata
    input wire logic [31:0] o_wb_dat, // rdata
    input wire logic o_wb_ack, // ack
    input wire logic i_full_duplex, // duplex
    input wire logic i_col_raw, // raw col
    input wire logic o_col, // col out
    input wire logic o_irq_powerdown_shared_pin, // pin out
    input wire logic o_irq_powerdown_shared_pin_oe, // pin oe
    input wire logic o_powerdown // pd
);
    // mirror of the control register, updated on the edge a write is taken
    reg [9:0] ctl_ff;
    wire ctl_we = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == `PCI_ADDR_CTRL;
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_ff <= 10'h108;
        end else if (ctl_we) begin
            ctl_ff <= {i_wb_sel[1] ? i_wb_dat[9:8] : ctl_ff[9:8],
                i_wb_sel[0] ? i_wb_dat[7:0] & 8'h1F : ctl_ff[7:0]};
        end
    end
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not acked");
    ctl_read_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == `PCI_ADDR_CTRL
        |-> o_wb_dat == {22'h0, ctl_ff}) else $error("control readback wrong");
    col_half_a: assert property (!i_full_duplex && i_col_raw |=> o_col)
        else $error("half duplex collision lost");
    col_full_a: assert property (i_full_duplex && i_col_raw
        |=> o_col == $past(ctl_ff[4])) else $error("full duplex collision gate wrong");
    col_quiet_a: assert property (!i_col_raw |=> !o_col)
        else $error("collision without cause");
    pin_idle_a: assert property (ctl_ff[2:1] == 2'b00
        |=> o_irq_powerdown_shared_pin == $past(ctl_ff[3])) else $error("pin not idle");
    pin_test_a: assert property (ctl_ff[2]
        |=> o_irq_powerdown_shared_pin == !$past(ctl_ff[3])) else $error("test irq missing");
    pin_oe_a: assert property (1'b1
        |=> o_irq_powerdown_shared_pin_oe == $past(ctl_ff[0])) else $error("pin enable wrong");
    pd_gate_a: assert property (o_irq_powerdown_shared_pin_oe |-> !o_powerdown)
        else $error("power-down while pin drives");
endmodule
bind pci_phy_ctrl pci_phy_ctrl_chk i_chk (.i_mclk, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_full_duplex, .i_col_raw, .o_col,
    .o_irq_powerdown_shared_pin, .o_irq_powerdown_shared_pin_oe, .o_powerdown);
`default_nettype wire

/* File: sim/pci_pin_model.sv */
// board side of the shared interrupt / power-down pin
`timescale 1ns/10ps
`default_nettype none
module pci_pin_model (
    input wire logic i_oe, // block drives pin
    input wire logic i_out, // block level
    input wire logic i_pd_req, // board pulls low
    output logic o_level // resolved level
);
    // released pin sits on its pull-up unless the board asks for power-down
    assign o_level = i_oe ? i_out : !i_pd_req;
endmodule
`default_nettype wire

/* File: sim/phy_ctrl_interrupt_config_test.sv */
// self-checking bench for the phy control register block
`timescale 1ns/10ps
`default_nettype none
`include "pci_regs.vh"
module phy_ctrl_interrupt_config_test;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] rxd = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [7:0] evt = 8'h0;
    logic fd = 1'b0, col_raw = 1'b0, loop = 1'b0, lwr = 1'b0, lrd = 1'b0, pd_req = 1'b0;
    wire [31:0] rdat;
    wire [3:0] txd;
    wire ack, col, pin_out, pin_oe, pdwn, irq, lvalid, pin_lvl;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rd;
    always #10 i_mclk = ~i_mclk;
    pci_phy_ctrl #(.NEVT(8)) i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wb_cyc(req),
        .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_event(evt), .i_full_duplex(fd), .i_col_raw(col_raw),
        .o_col(col), .i_far_loop(loop), .i_lb_wr(lwr), .i_lb_rxd(rxd), .i_lb_rd(lrd),
        .o_lb_txd(txd), .o_lb_valid(lvalid), .i_irq_powerdown_shared_pin(pin_lvl),
        .o_irq_powerdown_shared_pin(pin_out), .o_irq_powerdown_shared_pin_oe(pin_oe),
        .o_powerdown(pdwn), .o_irq(irq));
    pci_pin_model i_pin (.i_oe(pin_oe), .i_out(pin_out), .i_pd_req(pd_req), .o_level(pin_lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wb(input logic w, input logic [9:0] a, input logic [3:0] s,
        input logic [31:0] d);
        @(posedge i_mclk);
        req <= 1'b1;
        {we, adr, sel, wdat} <= {w, a, s, d};
        for (int t = 0; t < 50 && ack !== 1'b1; t++) @(posedge i_mclk);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t bus request not acknowledged", $time);
        end
        rd = rdat;
        req <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic t_reset;
        wb(1'b0, `PCI_ADDR_CTRL, 4'h3, 32'h0);
        chk(rd, 32'h0108);
        wb(1'b0, `PCI_ADDR_EVT, 4'h3, 32'h0);
        chk(rd, 32'h0);
        chk(32'({pin_oe, pin_out}), 32'h1);
    endtask
    task automatic t_regs;
        wb(1'b1, `PCI_ADDR_CTRL, 4'h3, 32'hFFFF);
        wb(1'b0, `PCI_ADDR_CTRL, 4'h3, 32'h0);
        chk(rd, 32'h031F);
        chk(32'(pin_out), 32'h0);
        wb(1'b1, 10'h3F0, 4'hF, 32'hFFFFFFFF);
        wb(1'b0, 10'h3F0, 4'hF, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_col;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, `PCI_ADDR_CTRL, 4'h1, {27'h0, i[1], 4'h8});
            fd <= i[0];
            col_raw <= 1'b1;
            cyc_n(2);
            chk(32'(col), 32'(!i[0] || i[1]));
            col_raw <= 1'b0;
            cyc_n(2);
            chk(32'(col), 32'h0);
        end
    endtask
    task automatic t_pin;
        pd_req <= 1'b1;
        wb(1'b1, `PCI_ADDR_CTRL, 4'h1, 32'h8);
        cyc_n(3);
        chk(32'({pin_oe, pdwn}), 32'h1);
        pd_req <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            wb(1'b1, `PCI_ADDR_CTRL, 4'h1, {28'h0, p[0], 3'b101});
            cyc_n(3);
            chk(32'({pin_oe, pdwn, pin_out}), {29'h0, 2'b10, !p[0]});
            cyc_n(20);
            chk(32'(pin_out), 32'(!p[0]));
            wb(1'b1, `PCI_ADDR_CTRL, 4'h1, {28'h0, p[0], 3'b001});
            cyc_n(3);
            chk(32'(pin_out), 32'(p[0]));
        end
    endtask
    task automatic t_evt;
        wb(1'b0, `PCI_ADDR_IRQ_STAT, 4'h1, 32'h0);
        wb(1'b1, `PCI_ADDR_EVT, 4'h1, 32'h20);
        wb(1'b1, `PCI_ADDR_IRQ_MASK, 4'h1, 32'h1);
        for (int g = 0; g < 2; g++) begin
            wb(1'b1, `PCI_ADDR_CTRL, 4'h1, {28'h0, 2'b10, g[0], 1'b1});
            evt <= 8'h21;
            cyc_n(1);
            evt <= 8'h0;
            cyc_n(3);
            chk(32'({pin_out, irq}), 32'({!g[0], g[0]}));
            wb(1'b0, `PCI_ADDR_EVT, 4'h3, 32'h0);
            chk(rd, 32'h2120);
            wb(1'b0, `PCI_ADDR_IRQ_STAT, 4'h1, 32'h0);
            chk(rd, 32'(g[0]));
            cyc_n(3);
            chk(32'({pin_out, irq}), 32'h2);
        end
    endtask
    task automatic t_fifo;
        int n;
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `PCI_ADDR_CTRL, 4'h2, {22'h0, c[1:0], 8'h0});
            loop <= 1'b1;
            lwr <= 1'b1;
            for (int k = 0; k < 8; k++) begin
                rxd <= k[3:0];
                cyc_n(1);
            end
            lwr <= 1'b0;
            lrd <= 1'b1;
            n = 0;
            repeat (12) begin
                cyc_n(1);
                if (lvalid === 1'b1) begin
                    chk(32'(txd), 32'(n));
                    n++;
                end
            end
            lrd <= 1'b0;
            loop <= 1'b0;
            chk(32'(n), (c == 3) ? 32'h8 : 32'(c + 4));
            wb(1'b0, `PCI_ADDR_IRQ_STAT, 4'h1, 32'h0);
            chk(32'(rd[1]), 32'h1);
        end
    endtask
    task automatic t_rerst;
        wb(1'b1, `PCI_ADDR_CTRL, 4'h3, 32'h0317);
        i_rst_b <= 1'b0;
        cyc_n(2);
        i_rst_b <= 1'b1;
        t_reset();
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        cyc_n(10);
        i_rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_col();
        t_pin();
        t_evt();
        t_fifo();
        t_rerst();
        stop_test();
    end
endmodule
`default_nettype wire
